// File: sdrc_pkg.sv
package sdrc_pkg;

	// register offsets
	localparam logic [7:0] SDRC_CFG_OFF  = 8'h00;
	localparam logic [7:0] SDRC_TIM_OFF  = 8'h04;
	localparam logic [7:0] SDRC_STAT_OFF = 8'h08;

	// configuration fields
	localparam int SDRC_CFG_AL_LSB   = 0;
	localparam int SDRC_CFG_CL_LSB   = 4;
	localparam int SDRC_CFG_BL8_BIT  = 8;
	localparam int SDRC_CFG_WIDE_BIT = 9;

	// timing fields, counts of pclk cycles
	localparam int SDRC_TIM_RAS_LSB = 0;
	localparam int SDRC_TIM_RTP_LSB = 8;
	localparam int SDRC_TIM_CP_LSB  = 16;

	// status fields
	localparam int SDRC_STAT_RD_LSB    = 0;
	localparam int SDRC_STAT_WR_LSB    = 4;
	localparam int SDRC_STAT_OPEN_LSB  = 8;
	localparam int SDRC_STAT_CLOSE_LSB = 12;

	// reset values
	localparam logic [31:0] SDRC_CFG_RST = 32'h0000_0031;
	localparam logic [31:0] SDRC_TIM_RST = 32'h0002_0204;

	// command address bit that selects the automatic row close
	localparam int SDRC_ROW_CLOSE_BIT = 10;

	// burst and prefetch figures in link clock cycles
	localparam logic [4:0] SDRC_HALF_BL4    = 5'h02;
	localparam logic [4:0] SDRC_HALF_BL8    = 5'h04;
	localparam logic [4:0] SDRC_PF_BL8_ADD  = 5'h02;
	localparam logic [4:0] SDRC_PF_GAP      = 5'h02;
	localparam logic [3:0] SDRC_WL_OFFSET   = 4'h1;

	localparam int SDRC_BANKS = 4;

	typedef struct packed {
		logic        cs_n;
		logic        ras_n;
		logic        cas_n;
		logic        we_n;
		logic [1:0]  bank;
		logic [13:0] addr;
	} sdrc_cmd_pins_t;

	typedef struct packed {
		logic [2:0] posted_latency;
		logic [2:0] column_wait;
		logic       bl8;
		logic [7:0] ras_min;
		logic [7:0] rtp;
		logic [7:0] cp;
	} sdrc_bank_cfg_t;

	typedef enum logic [2:0] {
		SDRC_NOP = 3'h0,
		SDRC_ACT = 3'h1,
		SDRC_RD  = 3'h2,
		SDRC_WR  = 3'h3,
		SDRC_PRE = 3'h4
	} sdrc_cmd_t;

	typedef enum logic [1:0] {
		SDRC_IDLE    = 2'b00,
		SDRC_OPEN    = 2'b01,
		SDRC_WAIT    = 2'b11,
		SDRC_CLOSING = 2'b10
	} sdrc_bank_st_t;

endpackage

// File: sdrc_bank_timer.sv
`timescale 1ns/1ps
module sdrc_bank_timer (
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// decoded commands for this bank
	input  wire logic                     ck_rise,
	input  wire logic                     act,
	input  wire logic                     rd_ac,
	input  wire logic                     wr_ac,
	input  wire logic                     pre,
	input  wire sdrc_pkg::sdrc_bank_cfg_t cfg,
	// bank state
	output logic                          row_open,
	output logic                          closing,
	output logic                          close_start
);
	import sdrc_pkg::*;

	sdrc_bank_st_t st_q, st_d;
	logic [7:0] ras_q, ras_d;
	logic [4:0] ck_cnt_q, ck_cnt_d;
	logic [7:0] rtp_q, rtp_d;
	logic       pf_q, pf_d;
	logic       is_rd_q, is_rd_d;
	logic [7:0] cp_q, cp_d;
	logic       open_q, open_d;
	logic       closing_q, closing_d;
	logic       start_q, start_d;
	logic [4:0] half;
	logic [4:0] pf_edge;
	logic [4:0] target;
	logic       ras_ok;
	logic       rtp_ok;

	always_comb begin
		half    = cfg.bl8 ? SDRC_HALF_BL8 : SDRC_HALF_BL4;
		pf_edge = {2'b00, cfg.posted_latency} + (cfg.bl8 ? SDRC_PF_BL8_ADD : 5'h00);
		// read: posted latency plus half burst; write: write delay plus half burst
		target  = is_rd_q ? ({2'b00, cfg.posted_latency} + half)
			: ({2'b00, cfg.posted_latency} + {2'b00, cfg.column_wait} - 5'h01 + half);
		ras_ok  = ras_q >= cfg.ras_min;
		rtp_ok  = pf_q && (rtp_q >= cfg.rtp);
		st_d     = st_q;
		ras_d    = (ras_q != 8'hFF) ? ras_q + 8'h01 : ras_q;
		ck_cnt_d = (ck_rise && ck_cnt_q != 5'h1F) ? ck_cnt_q + 5'h01 : ck_cnt_q;
		rtp_d    = (pf_q && rtp_q != 8'hFF) ? rtp_q + 8'h01 : rtp_q;
		pf_d     = pf_q;
		is_rd_d  = is_rd_q;
		cp_d     = cp_q;
		start_d  = 1'b0;
		if (!pf_q && ck_cnt_q >= pf_edge) begin
			pf_d  = 1'b1;
			rtp_d = 8'h00;
		end
		unique case (st_q)
			SDRC_IDLE: begin
				if (act) begin
					st_d  = SDRC_OPEN;
					ras_d = 8'h00;
				end
			end
			SDRC_OPEN: begin
				if (rd_ac || wr_ac) begin
					st_d     = SDRC_WAIT;
					ck_cnt_d = 5'h00;
					pf_d     = 1'b0;
					rtp_d    = 8'h00;
					is_rd_d  = rd_ac;
				end else if (pre) begin
					// controller holds the close back until the row-active minimum
					st_d    = SDRC_CLOSING;
					cp_d    = 8'h00;
					start_d = 1'b1;
				end
			end
			SDRC_WAIT: begin
				// close waits for the scheduled edge, row-active, read-to-close, prefetch gap
				if (ck_cnt_q >= target && ras_ok
					&& (!is_rd_q || (rtp_ok && ck_cnt_q >= pf_edge + SDRC_PF_GAP))) begin
					st_d    = SDRC_CLOSING;
					cp_d    = 8'h00;
					start_d = 1'b1;
				end
			end
			SDRC_CLOSING: begin
				// close period runs from the pclk cycle after the close itself, so the bank stays closing one cycle longer than cp
				cp_d = cp_q + 8'h01;
				if (cp_q >= cfg.cp) begin
					st_d = SDRC_IDLE;
				end
			end
		endcase
		open_d    = (st_d == SDRC_OPEN) || (st_d == SDRC_WAIT);
		closing_d = st_d == SDRC_CLOSING;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q      <= SDRC_IDLE;
			ras_q     <= 8'h00;
			ck_cnt_q  <= 5'h00;
			rtp_q     <= 8'h00;
			pf_q      <= 1'b0;
			is_rd_q   <= 1'b0;
			cp_q      <= 8'h00;
			open_q    <= 1'b0;
			closing_q <= 1'b0;
			start_q   <= 1'b0;
		end else begin
			st_q      <= st_d;
			ras_q     <= ras_d;
			ck_cnt_q  <= ck_cnt_d;
			rtp_q     <= rtp_d;
			pf_q      <= pf_d;
			is_rd_q   <= is_rd_d;
			cp_q      <= cp_d;
			open_q    <= open_d;
			closing_q <= closing_d;
			start_q   <= start_d;
		end
	end

	assign row_open    = open_q;
	assign closing     = closing_q;
	assign close_start = start_q;

endmodule // sdrc_bank_timer

// File: sdrc_autoclose.sv
`timescale 1ns/1ps
module sdrc_autoclose (
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// apb slave
	input  wire logic [7:0]               paddr,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// memory command pins
	input  wire logic                     mem_ck,
	input  wire sdrc_pkg::sdrc_cmd_pins_t cmd_pins,
	// data strobes
	output logic                          lower_byte_strobe,
	output logic                          lower_byte_strobe_oe_n,
	output logic                          upper_byte_strobe,
	output logic                          upper_byte_strobe_oe_n,
	// bank state
	output logic [3:0]                    bank_open,
	output logic [3:0]                    bank_closing,
	output logic [3:0]                    close_start
);
	import sdrc_pkg::*;

	logic           ck_s1_q, ck_s2_q, ck_s3_q;
	sdrc_cmd_pins_t cmd_s1_q, cmd_s2_q;
	logic           ck_rise;
	sdrc_cmd_t      cmd;
	sdrc_bank_cfg_t bcfg;
	logic [3:0]     read_delay;
	logic [3:0]     write_delay;

	// link inputs pass two flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_s1_q  <= 1'b0;
			ck_s2_q  <= 1'b0;
			ck_s3_q  <= 1'b0;
			cmd_s1_q <= '1;
			cmd_s2_q <= '1;
		end else begin
			ck_s1_q  <= mem_ck;
			ck_s2_q  <= ck_s1_q;
			ck_s3_q  <= ck_s2_q;
			cmd_s1_q <= cmd_pins;
			cmd_s2_q <= cmd_s1_q;
		end
	end

	// command decode on each rising link clock edge
	always_comb begin
		ck_rise = ck_s2_q && !ck_s3_q;
		cmd     = SDRC_NOP;
		if (ck_rise && !cmd_s2_q.cs_n) begin
			unique case ({cmd_s2_q.ras_n, cmd_s2_q.cas_n, cmd_s2_q.we_n})
				3'b011:  cmd = SDRC_ACT;
				3'b101:  cmd = SDRC_RD;
				3'b100:  cmd = SDRC_WR;
				3'b010:  cmd = SDRC_PRE;
				default: cmd = SDRC_NOP;
			endcase
		end
	end

	// apb registers
	logic [31:0] cfg_q, cfg_d;
	logic [31:0] tim_q, tim_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic [31:0] stat;

	always_comb begin
		read_delay  = {1'b0, cfg_q[SDRC_CFG_AL_LSB +: 3]} + {1'b0, cfg_q[SDRC_CFG_CL_LSB +: 3]};
		write_delay = read_delay - SDRC_WL_OFFSET;
		bcfg.posted_latency = cfg_q[SDRC_CFG_AL_LSB +: 3];
		bcfg.column_wait    = cfg_q[SDRC_CFG_CL_LSB +: 3];
		bcfg.bl8            = cfg_q[SDRC_CFG_BL8_BIT];
		bcfg.ras_min        = tim_q[SDRC_TIM_RAS_LSB +: 8];
		bcfg.rtp            = tim_q[SDRC_TIM_RTP_LSB +: 8];
		bcfg.cp             = tim_q[SDRC_TIM_CP_LSB +: 8];
		stat = 32'h0000_0000;
		stat[SDRC_STAT_RD_LSB +: 4]    = read_delay;
		stat[SDRC_STAT_WR_LSB +: 4]    = write_delay;
		stat[SDRC_STAT_OPEN_LSB +: 4]  = bank_open;
		stat[SDRC_STAT_CLOSE_LSB +: 4] = bank_closing;
		cfg_d     = cfg_q;
		tim_d     = tim_q;
		prdata_d  = 32'h0000_0000;
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		if (psel && !penable) begin
			pready_d = 1'b1;
			unique case (paddr)
				SDRC_CFG_OFF:  prdata_d = cfg_q;
				SDRC_TIM_OFF:  prdata_d = tim_q;
				SDRC_STAT_OFF: prdata_d = stat;
				default:       pslverr_d = 1'b1;
			endcase
		end
		if (psel && penable && pready_q && pwrite && !pslverr_q) begin
			if (paddr == SDRC_CFG_OFF) begin
				cfg_d = {22'h000000, pwdata[9:0]};
			end
			if (paddr == SDRC_TIM_OFF) begin
				tim_d = {8'h00, pwdata[23:0]};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q     <= SDRC_CFG_RST;
			tim_q     <= SDRC_TIM_RST;
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			cfg_q     <= cfg_d;
			tim_q     <= tim_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// one timer per bank, each closes on its own except on a close command with the row close bit set, which reaches every timer
	genvar b;
	generate
		for (b = 0; b < SDRC_BANKS; b++) begin : g_bank
			logic hit;
			assign hit = cmd_s2_q.bank == 2'(b);
			sdrc_bank_timer u_timer (
				.pclk        (pclk),
				.presetn     (presetn),
				.ck_rise     (ck_rise),
				.act         ((cmd == SDRC_ACT) && hit),
				.rd_ac       ((cmd == SDRC_RD) && hit && cmd_s2_q.addr[SDRC_ROW_CLOSE_BIT]),
				.wr_ac       ((cmd == SDRC_WR) && hit && cmd_s2_q.addr[SDRC_ROW_CLOSE_BIT]),
				.pre         ((cmd == SDRC_PRE) && (hit || cmd_s2_q.addr[SDRC_ROW_CLOSE_BIT])),
				.cfg         (bcfg),
				.row_open    (bank_open[b]),
				.closing     (bank_closing[b]),
				.close_start (close_start[b])
			);
		end
	endgenerate

	// read burst strobe window
	logic [4:0] rd_cnt_q, rd_cnt_d;
	logic       rd_act_q, rd_act_d;
	logic       lo_q, lo_d, lo_oe_n_q, lo_oe_n_d;
	logic       hi_q, hi_d, hi_oe_n_q, hi_oe_n_d;
	logic       window;

	always_comb begin
		rd_cnt_d = (ck_rise && rd_cnt_q != 5'h1F) ? rd_cnt_q + 5'h01 : rd_cnt_q;
		rd_act_d = rd_act_q;
		if (cmd == SDRC_RD) begin
			rd_cnt_d = 5'h00;
			rd_act_d = 1'b1;
		end
		window = rd_act_q && (rd_cnt_q >= {1'b0, read_delay})
			&& (rd_cnt_q < {1'b0, read_delay}
				+ (cfg_q[SDRC_CFG_BL8_BIT] ? SDRC_HALF_BL8 : SDRC_HALF_BL4));
		lo_d      = window && ck_s2_q;
		lo_oe_n_d = !window;
		hi_d      = window && ck_s2_q && cfg_q[SDRC_CFG_WIDE_BIT];
		hi_oe_n_d = !(window && cfg_q[SDRC_CFG_WIDE_BIT]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_cnt_q  <= 5'h00;
			rd_act_q  <= 1'b0;
			lo_q      <= 1'b0;
			lo_oe_n_q <= 1'b1;
			hi_q      <= 1'b0;
			hi_oe_n_q <= 1'b1;
		end else begin
			rd_cnt_q  <= rd_cnt_d;
			rd_act_q  <= rd_act_d;
			lo_q      <= lo_d;
			lo_oe_n_q <= lo_oe_n_d;
			hi_q      <= hi_d;
			hi_oe_n_q <= hi_oe_n_d;
		end
	end

	assign lower_byte_strobe      = lo_q;
	assign lower_byte_strobe_oe_n = lo_oe_n_q;
	assign upper_byte_strobe      = hi_q;
	assign upper_byte_strobe_oe_n = hi_oe_n_q;

endmodule // sdrc_autoclose

// File: sdrc_ctrl_model.sv
`timescale 1ns/1ps
module sdrc_ctrl_model (
	// link side
	output logic                     mem_ck,
	output sdrc_pkg::sdrc_cmd_pins_t cmd_pins
);
	import sdrc_pkg::*;
	// free running link clock, phase unrelated to pclk
	initial begin
		mem_ck = 1'b0;
		cmd_pins = '1;
		#137;
		forever #400 mem_ck = ~mem_ck;
	end
	// command held half a period on both sides of its rising edge
	task automatic issue(input logic [2:0] rcw, input logic [1:0] b, input logic a10);
		@(negedge mem_ck);
		cmd_pins = {1'b0, rcw, b, 3'h0, a10, 10'h015};
		@(posedge mem_ck);
		@(negedge mem_ck);
		cmd_pins = {1'b1, ~cmd_pins[18:0]};
	endtask
	// idle link cycles
	task automatic gap(input int n);
		repeat (n) @(posedge mem_ck);
	endtask
endmodule // sdrc_ctrl_model

// File: sdrc_autoclose_assertions.sv
`timescale 1ns/1ps
module sdrc_autoclose_assertions (
	// clock and reset
	input wire logic                     pclk,
	input wire logic                     presetn,
	// apb
	input wire logic [7:0]               paddr,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	// link
	input wire logic                     mem_ck,
	input wire sdrc_pkg::sdrc_cmd_pins_t cmd_pins,
	// strobes
	input wire logic                     lower_byte_strobe,
	input wire logic                     lower_byte_strobe_oe_n,
	input wire logic                     upper_byte_strobe,
	input wire logic                     upper_byte_strobe_oe_n,
	// bank state
	input wire logic [3:0]               bank_open,
	input wire logic [3:0]               bank_closing,
	input wire logic [3:0]               close_start
);
	import sdrc_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_rd_auto0;
		$rose(mem_ck) && !cmd_pins.cs_n && cmd_pins.bank == 2'h0
			&& {cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n} == 3'h5
			&& cmd_pins.addr[SDRC_ROW_CLOSE_BIT];
	endsequence
	sequence s_shut0;
		!close_start[0] && bank_closing[0] && !bank_open[0];
	endsequence
	sequence s_stat_rd;
		psel && penable && pready && !pwrite && paddr == SDRC_STAT_OFF;
	endsequence
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("late ready");
	property p_err; pslverr |-> pready && psel && penable; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_cs_open; close_start[0] |-> $past(bank_open[0]); endproperty
	a_cs_open: assert property (p_cs_open) else $error("close of idle bank");
	property p_cs_after; close_start[0] |=> s_shut0; endproperty
	a_cs_after: assert property (p_cs_after) else $error("row not closed");
	property p_ras; $rose(bank_open[0]) |-> !close_start[0] [*8]; endproperty
	a_ras: assert property (p_ras) else $error("close too soon");
	property p_gap; s_rd_auto0 |-> !close_start[0] [*8]; endproperty
	a_gap: assert property (p_gap) else $error("close before prefetch");
	property p_wl; s_stat_rd |-> prdata[7:4] == prdata[3:0] - 4'h1; endproperty
	a_wl: assert property (p_wl) else $error("write delay off");
	property p_up;
		!upper_byte_strobe_oe_n |-> !lower_byte_strobe_oe_n
			&& upper_byte_strobe == lower_byte_strobe;
	endproperty
	a_up: assert property (p_up) else $error("upper strobe wrong");
endmodule // sdrc_autoclose_assertions

bind sdrc_autoclose sdrc_autoclose_assertions i_chk (.pclk, .presetn, .paddr, .psel, .penable,
	.pwrite, .prdata, .pready, .pslverr, .mem_ck, .cmd_pins, .lower_byte_strobe,
	.lower_byte_strobe_oe_n, .upper_byte_strobe, .upper_byte_strobe_oe_n, .bank_open,
	.bank_closing, .close_start);

// File: sdrc_autoclose_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; \
	$display("BAD %s exp %0h got %0h", n, e, s); end end
module sdrc_autoclose_tb;
	import sdrc_pkg::*;
	localparam logic [2:0] C_ACT = 3'h3;
	localparam logic [2:0] C_RD  = 3'h5;
	localparam logic [2:0] C_WR  = 3'h4;
	localparam logic [2:0] C_PRE = 3'h2;
	logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, er, mem_ck;
	logic           lower_byte_strobe, lower_byte_strobe_oe_n;
	logic           upper_byte_strobe, upper_byte_strobe_oe_n;
	logic [7:0]     paddr;
	logic [31:0]    pwdata, prdata, rd;
	logic [3:0]     bank_open, bank_closing, close_start;
	sdrc_cmd_pins_t cmd_pins;
	int             n_fail, comparisons, cyc;

	sdrc_autoclose i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .mem_ck, .cmd_pins, .lower_byte_strobe, .lower_byte_strobe_oe_n,
		.upper_byte_strobe, .upper_byte_strobe_oe_n, .bank_open, .bank_closing, .close_start);
	sdrc_ctrl_model i_ctl (.mem_ck, .cmd_pins);

	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			test_done;
		end
	end

	task automatic test_done;
		if (n_fail == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// close period fixed at three cycles
	task automatic tim(input logic [7:0] ras, input logic [7:0] rtp);
		apb(1'b1, SDRC_TIM_OFF, {8'h00, 8'h03, rtp, ras});
	endtask

	// base is the expected pclk count from the call until close_start rises
	task automatic close_chk(input int b, input int base);
		int n = 0;
		int k = 0;
		while (close_start[b] !== 1'b1) begin
			@(posedge pclk);
			n++;
		end
		`CHK("close time", 1'b1, n >= base - 4 && n <= base + 6)
		while (bank_closing[b] !== 1'b1) @(posedge pclk);
		while (bank_closing[b] === 1'b1) begin
			@(posedge pclk);
			k++;
		end
		`CHK("close length", 4, k)
	endtask

	task automatic t_regs;
		apb(1'b0, SDRC_CFG_OFF, 32'h0);
		`CHK("cfg reset", SDRC_CFG_RST, rd)
		apb(1'b0, SDRC_TIM_OFF, 32'h0);
		`CHK("tim reset", SDRC_TIM_RST, rd)
		apb(1'b0, 8'h0C, 32'h0);
		`CHK("unmapped", 33'h1_0000_0000, {er, rd})
		apb(1'b1, SDRC_STAT_OFF, 32'hFFFF_FFFF);
		apb(1'b0, SDRC_STAT_OFF, 32'h0);
		`CHK("stat", 32'h0000_0034, rd)
		apb(1'b1, SDRC_CFG_OFF, 32'hFFFF_F231);
		apb(1'b0, SDRC_CFG_OFF, 32'h0);
		`CHK("cfg", 32'h0000_0231, rd)
	endtask

	task automatic t_rd;
		int lo = 0;
		int hi = 0;
		tim(8'h04, 8'h02);
		i_ctl.issue(C_ACT, 2'h0, 1'b0);
		i_ctl.issue(C_RD, 2'h0, 1'b1);
		i_ctl.issue(C_ACT, 2'h1, 1'b0);
		close_chk(0, 8);
		`CHK("other bank", 1'b1, bank_open[1])
		while (lower_byte_strobe_oe_n !== 1'b0) @(posedge pclk);
		`CHK("upper strobe on", 1'b0, upper_byte_strobe_oe_n)
		// window of half a burst of link cycles, strobe high half of it
		while (lower_byte_strobe_oe_n === 1'b0) begin
			lo++;
			hi += lower_byte_strobe;
			@(posedge pclk);
		end
		`CHK("strobe window", 16, lo)
		`CHK("strobe high", 8, hi)
	endtask

	// explicit close once the row-active minimum has passed
	task automatic t_close;
		i_ctl.issue(C_ACT, 2'h2, 1'b0);
		i_ctl.gap(2);
		`CHK("open before close", 1'b1, bank_open[2])
		i_ctl.issue(C_PRE, 2'h2, 1'b0);
		`CHK("closing", 1'b1, bank_closing[2])
		`CHK("closed row", 1'b0, bank_open[2])
	endtask

	task automatic t_push(input logic [1:0] b, input logic [7:0] ras, input logic [7:0] rtp,
		input int base);
		tim(ras, rtp);
		i_ctl.issue(C_ACT, b, 1'b0);
		i_ctl.issue(C_RD, b, 1'b1);
		close_chk(b, base);
	endtask

	task automatic t_bl8;
		apb(1'b1, SDRC_CFG_OFF, 32'h0000_0130);
		tim(8'h04, 8'h02);
		i_ctl.gap(4);
		i_ctl.issue(C_ACT, 2'h0, 1'b0);
		i_ctl.issue(C_RD, 2'h0, 1'b1);
		close_chk(0, 32);
		while (lower_byte_strobe_oe_n !== 1'b0) @(posedge pclk);
		`CHK("upper strobe off", 1'b1, upper_byte_strobe_oe_n)
	endtask

	task automatic t_wr;
		apb(1'b1, SDRC_CFG_OFF, 32'h0000_0031);
		i_ctl.issue(C_WR, 2'h1, 1'b1);
		close_chk(1, 40);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_rd;
		t_push(2'h2, 8'h50, 8'h02, 67);
		t_push(2'h3, 8'h04, 8'h32, 61);
		t_close;
		t_bl8;
		t_wr;
		test_done;
	end
endmodule // sdrc_autoclose_tb
